// ---- pkg/tstb_pkg.sv ----
// ****************************************************************
// Trim bank constants and shared arithmetic
// ****************************************************************
package tstb_pkg;

  // ****************************************************************
  // Bus geometry
  // ****************************************************************
  // Byte address is four times the register index, so 18 bits reach 0xFE82
  localparam int AXI_ADDR_W = 18;
  localparam int AXI_DATA_W = 32;
  localparam int ADC_W = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Register indices (byte address = index * 4)
  // ****************************************************************
  localparam logic [15:0] IDX_SENSE1_TRIM_UPPER = 16'hFE7C;
  localparam logic [15:0] IDX_SENSE1_TRIM_LOWER = 16'hFE7D;
  localparam logic [15:0] IDX_SENSE2_TRIM_UPPER = 16'hFE7E;
  localparam logic [15:0] IDX_SENSE2_TRIM_LOWER = 16'hFE7F;
  localparam logic [15:0] IDX_SENSE1_CURRENT = 16'hFE80;
  localparam logic [15:0] IDX_SENSE2_CURRENT = 16'hFE81;
  localparam logic [15:0] IDX_USER_SCRATCH = 16'hFE82;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int TRIM_SIGN_BIT = 1;  // 1 = negative correction
  localparam int TRIM_MSB_BIT = 0;   // Ninth magnitude bit
  localparam int COARSE_HI = 7;
  localparam int COARSE_LO = 6;
  localparam int FINE_HI = 5;
  localparam int FINE_LO = 0;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [1:0] RST_TRIM_UPPER = 2'h0;
  localparam logic [7:0] RST_TRIM_LOWER = 8'h00;
  localparam logic [7:0] RST_CURRENT = 8'h00;  // Coarse 00 selects 10 uA
  localparam logic [7:0] RST_USER = 8'h00;

  // ****************************************************************
  // Excitation current scale, in picoamperes
  // ****************************************************************
  localparam int FINE_STEP_PA = 156250;
  localparam int COARSE_STEP_PA = 10000000;
  localparam logic [8:0] COARSE_STEP_UNITS = 9'(COARSE_STEP_PA / FINE_STEP_PA);

  // Register index match; the two low byte-address bits are ignored
  function automatic logic addrIs(input logic [AXI_ADDR_W-1:0] addr,
                                  input logic [15:0] idx);
    return addr[AXI_ADDR_W-1:2] == idx;
  endfunction

  // Offset correction with saturation at both ends of the reading range
  function automatic logic [ADC_W-1:0] applyTrim(input logic [ADC_W-1:0] raw,
                                                 input logic neg,
                                                 input logic [8:0] mag);
    logic [ADC_W:0] sum;
    logic [ADC_W-1:0] mag16;
    mag16 = {7'h00, mag};
    sum = {1'b0, raw} + {1'b0, mag16};
    if (neg) begin
      applyTrim = (raw >= mag16) ? (raw - mag16) : 16'h0000;
    end else begin
      applyTrim = sum[ADC_W] ? 16'hFFFF : sum[ADC_W-1:0];
    end
  endfunction

  // Total excitation in fine steps: coarse step (c+1) plus fine count
  function automatic logic [8:0] excUnits(input logic [1:0] coarse,
                                          input logic [5:0] fine);
    logic [8:0] base;
    base = 9'(({7'h00, coarse} + 9'h001) * COARSE_STEP_UNITS);
    return base + {3'h0, fine};
  endfunction

endpackage

// ---- hw/tstb_sense_channel.sv ----
`timescale 1ns/1ps
// ****************************************************************
// One sensing input: trimmed reading and excitation setting
// ****************************************************************
module tstb_sense_channel
  import tstb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic trimNeg,
  input wire logic [8:0] trimMag,
  input wire logic [1:0] coarseSel,
  input wire logic [5:0] fineAdj,
  input wire logic [ADC_W-1:0] adcRaw,
  output logic [ADC_W-1:0] adcTrimmed,
  output logic [8:0] excitation
);

  // Whole channel state in one record
  typedef struct packed {
    logic [ADC_W-1:0] trimmed;  // Corrected reading
    logic [8:0] exc;            // Excitation in 156.25 nA steps
  } tstb_chan_state_type;

  tstb_chan_state_type state_r;
  tstb_chan_state_type state_nxt;

  // Next state: one cycle of latency from reading to output
  always_comb begin
    state_nxt = state_r;
    state_nxt.trimmed = applyTrim(adcRaw, trimNeg, trimMag);
    state_nxt.exc = excUnits(coarseSel, fineAdj);
  end

  // Registered state; reset shows zero reading and zero excitation
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign adcTrimmed = state_r.trimmed;
  assign excitation = state_r.exc;

endmodule

// ---- hw/tstb_trim_bank.sv ----
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
module tstb_trim_bank
  import tstb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  // AXI4-Lite slave
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [AXI_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [AXI_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Sensing inputs
  input wire logic [ADC_W-1:0] adcRaw1,
  input wire logic [ADC_W-1:0] adcRaw2,
  output logic [ADC_W-1:0] adcTrimmed1,
  output logic [ADC_W-1:0] adcTrimmed2,
  output logic sense1TrimNeg,
  output logic [8:0] sense1TrimMag,
  output logic sense2TrimNeg,
  output logic [8:0] sense2TrimMag,
  output logic [1:0] sense1Coarse,
  output logic [5:0] sense1Fine,
  output logic [1:0] sense2Coarse,
  output logic [5:0] sense2Fine,
  output logic [8:0] sense1Excitation,
  output logic [8:0] sense2Excitation
);

  // ****************************************************************
  // State record
  // ****************************************************************
  typedef struct packed {
    logic awHeld;                    // Write address taken, not yet used
    logic [AXI_ADDR_W-1:0] awAddr;
    logic wHeld;                     // Write data taken, not yet used
    logic [AXI_DATA_W-1:0] wData;
    logic [3:0] wStrb;
    logic awReady;
    logic wReady;
    logic bValid;
    logic [1:0] bResp;
    logic arReady;
    logic rValid;
    logic [AXI_DATA_W-1:0] rData;
    logic [1:0] rResp;
    logic [1:0] s1Upper;             // Sign and magnitude MSB only
    logic [7:0] s1Lower;
    logic [1:0] s2Upper;
    logic [7:0] s2Lower;
    logic [7:0] s1Cur;
    logic [7:0] s2Cur;
    logic [7:0] user;
  } tstb_bank_state_type;

  tstb_bank_state_type state_r;
  tstb_bank_state_type state_nxt;

  // Handshake and write-path helpers
  logic awTake;
  logic wTake;
  logic arTake;
  logic wrFire;                      // Register write happens this edge
  logic [AXI_ADDR_W-1:0] wrAddr;
  logic [AXI_DATA_W-1:0] wrData;
  logic [3:0] wrStrb;

  assign awTake = s_axi_awvalid && state_r.awReady;
  assign wTake = s_axi_wvalid && state_r.wReady;
  assign arTake = s_axi_arvalid && state_r.arReady;
  // Held beat wins; otherwise use the beat arriving now
  assign wrAddr = state_r.awHeld ? state_r.awAddr : s_axi_awaddr;
  assign wrData = state_r.wHeld ? state_r.wData : s_axi_wdata;
  assign wrStrb = state_r.wHeld ? state_r.wStrb : s_axi_wstrb;
  assign wrFire = (state_r.awHeld || awTake) && (state_r.wHeld || wTake) && !state_r.bValid;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  // Address and data may come in either order; the write lands once both
  // are present, so a lone beat is parked rather than refused
  always_comb begin
    state_nxt = state_r;
    // Park beats that arrive alone
    if (awTake) begin
      state_nxt.awHeld = 1'b1;
      state_nxt.awAddr = s_axi_awaddr;
    end
    if (wTake) begin
      state_nxt.wHeld = 1'b1;
      state_nxt.wData = s_axi_wdata;
      state_nxt.wStrb = s_axi_wstrb;
    end
    // Commit the write and raise the response
    if (wrFire) begin
      state_nxt.awHeld = 1'b0;
      state_nxt.wHeld = 1'b0;
      state_nxt.bValid = 1'b1;
      state_nxt.bResp = RESP_OKAY;
      // Registers are one byte wide; only lane 0 carries them
      if (addrIs(wrAddr, IDX_SENSE1_TRIM_UPPER)) begin
        if (wrStrb[0]) begin
          state_nxt.s1Upper = wrData[TRIM_SIGN_BIT:TRIM_MSB_BIT];
        end
      end else if (addrIs(wrAddr, IDX_SENSE1_TRIM_LOWER)) begin
        if (wrStrb[0]) begin
          state_nxt.s1Lower = wrData[7:0];
        end
      end else if (addrIs(wrAddr, IDX_SENSE2_TRIM_UPPER)) begin
        if (wrStrb[0]) begin
          state_nxt.s2Upper = wrData[TRIM_SIGN_BIT:TRIM_MSB_BIT];
        end
      end else if (addrIs(wrAddr, IDX_SENSE2_TRIM_LOWER)) begin
        if (wrStrb[0]) begin
          state_nxt.s2Lower = wrData[7:0];
        end
      end else if (addrIs(wrAddr, IDX_SENSE1_CURRENT)) begin
        if (wrStrb[0]) begin
          state_nxt.s1Cur = wrData[7:0];
        end
      end else if (addrIs(wrAddr, IDX_SENSE2_CURRENT)) begin
        if (wrStrb[0]) begin
          state_nxt.s2Cur = wrData[7:0];
        end
      end else if (addrIs(wrAddr, IDX_USER_SCRATCH)) begin
        if (wrStrb[0]) begin
          state_nxt.user = wrData[7:0];
        end
      end else begin
        // Unmapped: nothing stored, error answered
        state_nxt.bResp = RESP_SLVERR;
      end
    end
    // Response accepted by the master
    if (state_r.bValid && s_axi_bready) begin
      state_nxt.bValid = 1'b0;
    end
    // No new beat on a channel while its own beat is parked or a response is pending
    state_nxt.awReady = !state_nxt.awHeld && !state_nxt.bValid;
    state_nxt.wReady = !state_nxt.wHeld && !state_nxt.bValid;
    // Read: capture data at the address handshake
    if (arTake) begin
      state_nxt.rValid = 1'b1;
      state_nxt.rResp = RESP_OKAY;
      state_nxt.rData = 32'h0000_0000;
      if (addrIs(s_axi_araddr, IDX_SENSE1_TRIM_UPPER)) begin
        state_nxt.rData[1:0] = state_r.s1Upper;
      end else if (addrIs(s_axi_araddr, IDX_SENSE1_TRIM_LOWER)) begin
        state_nxt.rData[7:0] = state_r.s1Lower;
      end else if (addrIs(s_axi_araddr, IDX_SENSE2_TRIM_UPPER)) begin
        state_nxt.rData[1:0] = state_r.s2Upper;
      end else if (addrIs(s_axi_araddr, IDX_SENSE2_TRIM_LOWER)) begin
        state_nxt.rData[7:0] = state_r.s2Lower;
      end else if (addrIs(s_axi_araddr, IDX_SENSE1_CURRENT)) begin
        state_nxt.rData[7:0] = state_r.s1Cur;
      end else if (addrIs(s_axi_araddr, IDX_SENSE2_CURRENT)) begin
        state_nxt.rData[7:0] = state_r.s2Cur;
      end else if (addrIs(s_axi_araddr, IDX_USER_SCRATCH)) begin
        state_nxt.rData[7:0] = state_r.user;
      end else begin
        state_nxt.rResp = RESP_SLVERR;
      end
    end
    if (state_r.rValid && s_axi_rready) begin
      state_nxt.rValid = 1'b0;
    end
    state_nxt.arReady = !state_nxt.rValid;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // coarse default 10 uA
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_r <= '0;
      state_r.s1Upper <= RST_TRIM_UPPER;
      state_r.s1Lower <= RST_TRIM_LOWER;
      state_r.s2Upper <= RST_TRIM_UPPER;
      state_r.s2Lower <= RST_TRIM_LOWER;
      state_r.s1Cur <= RST_CURRENT;
      state_r.s2Cur <= RST_CURRENT;
      state_r.user <= RST_USER;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign s_axi_awready = state_r.awReady;
  assign s_axi_wready = state_r.wReady;
  assign s_axi_bvalid = state_r.bValid;
  assign s_axi_bresp = state_r.bResp;
  assign s_axi_arready = state_r.arReady;
  assign s_axi_rvalid = state_r.rValid;
  assign s_axi_rdata = state_r.rData;
  assign s_axi_rresp = state_r.rResp;
  assign sense1TrimNeg = state_r.s1Upper[TRIM_SIGN_BIT];
  assign sense2TrimNeg = state_r.s2Upper[TRIM_SIGN_BIT];
  assign sense1TrimMag = {state_r.s1Upper[TRIM_MSB_BIT], state_r.s1Lower};
  assign sense2TrimMag = {state_r.s2Upper[TRIM_MSB_BIT], state_r.s2Lower};
  assign sense1Coarse = state_r.s1Cur[COARSE_HI:COARSE_LO];
  assign sense1Fine = state_r.s1Cur[FINE_HI:FINE_LO];
  assign sense2Coarse = state_r.s2Cur[COARSE_HI:COARSE_LO];
  assign sense2Fine = state_r.s2Cur[FINE_HI:FINE_LO];

  // Same channel logic serves both inputs
  tstb_sense_channel u_sense1 (
    .ref_clk(ref_clk),
    .srst(srst),
    .trimNeg(sense1TrimNeg),
    .trimMag(sense1TrimMag),
    .coarseSel(sense1Coarse),
    .fineAdj(sense1Fine),
    .adcRaw(adcRaw1),
    .adcTrimmed(adcTrimmed1),
    .excitation(sense1Excitation)
  );

  tstb_sense_channel u_sense2 (
    .ref_clk(ref_clk),
    .srst(srst),
    .trimNeg(sense2TrimNeg),
    .trimMag(sense2TrimMag),
    .coarseSel(sense2Coarse),
    .fineAdj(sense2Fine),
    .adcRaw(adcRaw2),
    .adcTrimmed(adcTrimmed2),
    .excitation(sense2Excitation)
  );

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  logic [ADC_W-1:0] mag1Wide;
  logic [ADC_W:0] posSum1;
  assign mag1Wide = {7'h00, sense1TrimMag};
  assign posSum1 = {1'b0, adcRaw1} + {1'b0, mag1Wide};

  property p_trim_negative;
    sense1TrimNeg && (adcRaw1 >= mag1Wide) |=> adcTrimmed1 == $past(adcRaw1) - $past(mag1Wide);
  endproperty
  a_trim_negative: assert property (p_trim_negative) else $error("negative trim wrong");

  property p_trim_positive;
    !sense1TrimNeg && !posSum1[ADC_W] |=> adcTrimmed1 == $past(adcRaw1) + $past(mag1Wide);
  endproperty
  a_trim_positive: assert property (p_trim_positive) else $error("positive trim wrong");

  property p_lower1_write;
    wrFire && wrStrb[0] && addrIs(wrAddr, IDX_SENSE1_TRIM_LOWER)
      |=> sense1TrimMag[7:0] == $past(wrData[7:0]) && $stable(sense1TrimMag[8]);
  endproperty
  a_lower1_write: assert property (p_lower1_write) else $error("trim lower write lost");

  property p_upper2_write;
    wrFire && wrStrb[0] && addrIs(wrAddr, IDX_SENSE2_TRIM_UPPER)
      |=> sense2TrimMag[8] == $past(wrData[0]) && sense2TrimNeg == $past(wrData[1]);
  endproperty
  a_upper2_write: assert property (p_upper2_write) else $error("trim upper write lost");

  property p_coarse1;
    !srst |=> sense1Excitation[8:6] == {1'b0, $past(sense1Coarse)} + 3'h1;
  endproperty
  a_coarse1: assert property (p_coarse1) else $error("first coarse step wrong");

  property p_fine1;
    !srst |=> sense1Excitation[5:0] == $past(sense1Fine);
  endproperty
  a_fine1: assert property (p_fine1) else $error("first fine step wrong");

  property p_coarse2;
    sense2Coarse == 2'h3 |=> sense2Excitation[8:6] == 3'h4;
  endproperty
  a_coarse2: assert property (p_coarse2) else $error("second coarse step wrong");

  property p_fine2;
    $stable(sense2Fine) [*2] |-> sense2Excitation[5:0] == sense2Fine;
  endproperty
  a_fine2: assert property (p_fine2) else $error("second fine step wrong");

  property p_reset_coarse;
    $fell(srst) |-> sense1Coarse == 2'h0 && sense2Coarse == 2'h0 && !s_axi_awready;
  endproperty
  a_reset_coarse: assert property (p_reset_coarse) else $error("coarse default wrong");

  property p_user_store;
    wrFire && wrStrb[0] && addrIs(wrAddr, IDX_USER_SCRATCH)
      |=> state_r.user == $past(wrData[7:0]) && s_axi_bvalid && s_axi_bresp == RESP_OKAY;
  endproperty
  a_user_store: assert property (p_user_store) else $error("user byte not stored");

  property p_reserved_zero;
    arTake && addrIs(s_axi_araddr, IDX_SENSE1_TRIM_UPPER) |=> s_axi_rvalid && s_axi_rdata[31:2] == 30'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

  c_write_done: cover property (s_axi_bvalid && s_axi_bready);
  c_read_done: cover property (s_axi_rvalid && s_axi_rready);
  c_floor: cover property (sense1TrimNeg && adcRaw1 < mag1Wide);
  c_coarse_max: cover property (sense2Coarse == 2'h3);

endmodule

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Trim bank bench: register traffic over AXI4-Lite, sense outputs
// ****************************************************************
module tb_top
  import tstb_pkg::*;
;
  localparam int CYCLE_LIMIT = 5000;  // Whole run needs well under a thousand cycles
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [AXI_ADDR_W-1:0] awAddr = '0, arAddr = '0;
  logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
  logic [AXI_DATA_W-1:0] wData = '0;
  logic [3:0] wStrb = 4'h0;
  logic awReady, wReady, bValid, arReady, rValid;
  logic [1:0] bResp, rResp;
  logic [AXI_DATA_W-1:0] rData;
  logic [ADC_W-1:0] adcRaw1 = '0, adcRaw2 = '0, adcTrimmed1, adcTrimmed2;
  logic s1Neg, s2Neg;
  logic [8:0] s1Mag, s2Mag, s1Exc, s2Exc;
  logic [1:0] s1Coarse, s2Coarse;
  logic [5:0] s1Fine, s2Fine;
  int nMismatch = 0;
  int comparisons = 0;
  int cycles = 0;

  // Free-running 200 MHz clock
  always #2.5 ref_clk = ~ref_clk;

  tstb_trim_bank DUT (
    .ref_clk(ref_clk), .srst(srst),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .adcRaw1(adcRaw1), .adcRaw2(adcRaw2),
    .adcTrimmed1(adcTrimmed1), .adcTrimmed2(adcTrimmed2),
    .sense1TrimNeg(s1Neg), .sense1TrimMag(s1Mag), .sense2TrimNeg(s2Neg), .sense2TrimMag(s2Mag),
    .sense1Coarse(s1Coarse), .sense1Fine(s1Fine), .sense2Coarse(s2Coarse), .sense2Fine(s2Fine),
    .sense1Excitation(s1Exc), .sense2Excitation(s2Exc)
  );

  // ****************************************************************
  // Reporting
  // ****************************************************************
  // Single exit point for the normal end and for a hang
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", comparisons, nMismatch);
    if (nMismatch == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Four-state compare so an unknown never passes
  task automatic check(input string what, input logic [31:0] expVal, input logic [31:0] gotVal);
    comparisons++;
    if (gotVal !== expVal) begin
      $display("MISMATCH %s expected %h seen %h", what, expVal, gotVal);
      nMismatch++;
    end
  endtask

  // Hang guard: counts as a mismatch and closes the run
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles >= CYCLE_LIMIT) begin
      nMismatch++;
      conclude();
    end
  end

  // ****************************************************************
  // Bus tasks
  // ****************************************************************
  // Byte address is four times the register index
  function automatic logic [AXI_ADDR_W-1:0] byteAddr(input logic [15:0] idx);
    return {idx, 2'b00};
  endfunction

  // One write; AW and W offered together, each released when taken
  task automatic axiWrite(input logic [15:0] idx, input logic [7:0] val,
                          input logic [3:0] strb, input logic [1:0] expResp);
    bit done;
    done = 0;
    @(posedge ref_clk);
    awAddr <= byteAddr(idx);
    wData <= {24'h00_0000, val};
    wStrb <= strb;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    while (!done) begin
      @(posedge ref_clk);
      if (awValid && awReady) awValid <= 1'b0;
      if (wValid && wReady) wValid <= 1'b0;
      if (bValid && bReady) begin
        check("bresp", {30'h0, expResp}, {30'h0, bResp});
        bReady <= 1'b0;
        done = 1;
      end
    end
  endtask

  // One read; response data taken at the handshake edge
  task automatic axiRead(input logic [15:0] idx, input logic [31:0] expData,
                         input logic [1:0] expResp);
    bit done;
    done = 0;
    @(posedge ref_clk);
    arAddr <= byteAddr(idx);
    arValid <= 1'b1;
    rReady <= 1'b1;
    while (!done) begin
      @(posedge ref_clk);
      if (arValid && arReady) arValid <= 1'b0;
      if (rValid && rReady) begin
        check("rdata", expData, rData);
        check("rresp", {30'h0, expResp}, {30'h0, rResp});
        rReady <= 1'b0;
        done = 1;
      end
    end
  endtask

  // Let the register-to-output pipeline settle, then look between edges
  task automatic settle();
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    logic [15:0] regs [7];
    logic [8:0] expExc;
    regs = '{IDX_SENSE1_TRIM_UPPER, IDX_SENSE1_TRIM_LOWER, IDX_SENSE2_TRIM_UPPER,
             IDX_SENSE2_TRIM_LOWER, IDX_SENSE1_CURRENT, IDX_SENSE2_CURRENT, IDX_USER_SCRATCH};
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (2) @(posedge ref_clk);

    // Every register comes up zero; coarse 00 means 10 uA, i.e. 64 fine steps
    foreach (regs[i]) axiRead(regs[i], 32'h0000_0000, RESP_OKAY);
    // Readings change on the edge at which the last read ended
    adcRaw1 <= 16'h03E8;
    adcRaw2 <= 16'h03E8;
    #1;
    check("s1Coarse", 32'h0000_0000, {30'h0, s1Coarse});
    check("s2Coarse", 32'h0000_0000, {30'h0, s2Coarse});
    check("s1Exc", 32'h0000_0040, {23'h0, s1Exc});
    check("s2Exc", 32'h0000_0040, {23'h0, s2Exc});
    $display("TEST reset values done");

    // First input: negative trim of 0x15A, reserved bits dropped
    axiWrite(IDX_SENSE1_TRIM_UPPER, 8'hFF, 4'hF, RESP_OKAY);
    axiWrite(IDX_SENSE1_TRIM_LOWER, 8'h5A, 4'hF, RESP_OKAY);
    axiRead(IDX_SENSE1_TRIM_UPPER, 32'h0000_0003, RESP_OKAY);
    axiRead(IDX_SENSE1_TRIM_LOWER, 32'h0000_005A, RESP_OKAY);
    settle();
    check("s1Neg", 32'h0000_0001, {31'h0, s1Neg});
    check("s1Mag", 32'h0000_015A, {23'h0, s1Mag});
    check("adcTrimmed1 neg", 32'h0000_028E, {16'h0, adcTrimmed1});
    // Positive polarity, same magnitude
    axiWrite(IDX_SENSE1_TRIM_UPPER, 8'h01, 4'hF, RESP_OKAY);
    settle();
    check("s1Neg pos", 32'h0000_0000, {31'h0, s1Neg});
    check("adcTrimmed1 pos", 32'h0000_0542, {16'h0, adcTrimmed1});
    $display("TEST first input trim done");

    // Second input trim, first input must stay untouched
    axiWrite(IDX_SENSE2_TRIM_UPPER, 8'hFE, 4'hF, RESP_OKAY);
    axiWrite(IDX_SENSE2_TRIM_LOWER, 8'h0F, 4'hF, RESP_OKAY);
    axiRead(IDX_SENSE2_TRIM_UPPER, 32'h0000_0002, RESP_OKAY);
    settle();
    check("s2Neg", 32'h0000_0001, {31'h0, s2Neg});
    check("s2Mag", 32'h0000_000F, {23'h0, s2Mag});
    check("adcTrimmed2", 32'h0000_03D9, {16'h0, adcTrimmed2});
    check("adcTrimmed1 kept", 32'h0000_0542, {16'h0, adcTrimmed1});
    // Both ends of the reading range saturate rather than wrap
    @(posedge ref_clk);
    adcRaw1 <= 16'hFFF0;
    adcRaw2 <= 16'h0005;
    settle();
    check("adcTrimmed1 ceiling", 32'h0000_FFFF, {16'h0, adcTrimmed1});
    check("adcTrimmed2 floor", 32'h0000_0000, {16'h0, adcTrimmed2});
    $display("TEST second input trim done");

    // All four coarse codes on both inputs, fine count added on top
    for (int c = 0; c < 4; c++) begin
      axiWrite(IDX_SENSE1_CURRENT, 8'(c * 64 + 63), 4'hF, RESP_OKAY);
      axiWrite(IDX_SENSE2_CURRENT, 8'(c * 64 + 5), 4'hF, RESP_OKAY);
      axiRead(IDX_SENSE1_CURRENT, 32'(c * 64 + 63), RESP_OKAY);
      settle();
      check("s1Coarse", 32'(c), {30'h0, s1Coarse});
      check("s1Fine", 32'h0000_003F, {26'h0, s1Fine});
      check("s2Coarse", 32'(c), {30'h0, s2Coarse});
      check("s2Fine", 32'h0000_0005, {26'h0, s2Fine});
      expExc = 9'((c + 1) * 64 + 63);
      check("s1Exc", {23'h0, expExc}, {23'h0, s1Exc});
      expExc = 9'((c + 1) * 64 + 5);
      check("s2Exc", {23'h0, expExc}, {23'h0, s2Exc});
    end
    $display("TEST current source done");

    // User byte keeps any value; lane 0 disabled stores nothing
    axiWrite(IDX_USER_SCRATCH, 8'hA5, 4'hF, RESP_OKAY);
    axiRead(IDX_USER_SCRATCH, 32'h0000_00A5, RESP_OKAY);
    axiWrite(IDX_USER_SCRATCH, 8'h11, 4'hE, RESP_OKAY);
    axiRead(IDX_USER_SCRATCH, 32'h0000_00A5, RESP_OKAY);
    // Unmapped place answers with an error and stores nothing
    axiWrite(16'hFE83, 8'h77, 4'hF, RESP_SLVERR);
    axiRead(16'hFE83, 32'h0000_0000, RESP_SLVERR);
    #1;
    check("s1Mag kept", 32'h0000_015A, {23'h0, s1Mag});
    $display("TEST user byte and unmapped done");
    conclude();
  end
endmodule
